//--- hw/adc_mode_ctrl.v
// Strap decoding, mode, calibration and output framing of the converter
//
// Notes on behaviour
// R1 - Floating or mid range pin enters extended mode
// R2 - Range pin low 650 mV, high 870 mV
// R3 - Swing pin high normal, low reduced amplitude
// R4 - Extended mode: swing pin is serial clock
// R5 - Edge pin picks forwarded clock data edge
// R6 - Edge pin floating gives double data rate
// R7 - Extended mode: edge pin is serial data
// R8 - Clock reset pulse restarts forwarded clock generation
// R9 - Power-down pin high holds device powered down
// R10 - Calibrate pin 80 low, 80 high starts calibration
// R11 - Firm range pin: delay pin picks calibration delay
// R12 - Floating range pin: delay pin is serial select
// R13 - Sample on both input clock edges
// R14 - Results coded offset binary
// R15 - Default mode spreads samples over four buses
// R16 - Half mode uses third and fourth buses only
// R17 - Every bus word is eight bits
// R18 - Calibration flag high throughout calibration
// R19 - Sampling starts on input clock falling edge
// R20 - Extended mode ignores straps, registers take over
`include "adc_ctrl_defs.vh"
module adc_mode_ctrl #(
   parameter DW = 8,
   parameter [23:0] CAL_DLY_SHORT = `CAL_DLY_SHORT_DEF,
   parameter [23:0] CAL_DLY_LONG = `CAL_DLY_LONG_DEF,
   parameter [23:0] CAL_LEN = `CAL_LEN_DEF
) (
   // Clock and reset
   input wire clk_i,
   input wire rst_i,
   // Wishbone slave
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_we_i,
   input wire [3:0] wb_adr_i,
   input wire [3:0] wb_sel_i,
   input wire [31:0] wb_dat_i,
   output reg [31:0] wb_dat_o,
   output reg wb_ack_o,
   // Strap and control pins
   input wire [1:0] range_strap_i,
   input wire [1:0] edge_strap_i,
   input wire output_swing_select_i,
   input wire calibration_delay_select_i,
   input wire output_clock_reset_i,
   input wire power_down_pin_i,
   input wire cal_pin_i,
   // Converter input clock and raw signed sample
   input wire in_clk_i,
   input wire [DW-1:0] sample_i,
   // Decoded settings
   output reg extended_control_enable_o,
   output reg range_870_o,
   output reg swing_normal_o,
   output reg ddr_o,
   output reg edge_rise_o,
   output reg half_mode_o,
   output reg power_down_o,
   output reg calibration_running_flag_o,
   // Serial interface pins passed on
   output reg serial_clk_o,
   output reg serial_data_in_o,
   output reg serial_select_o,
   // Output buses and forwarded clock
   output wire [DW-1:0] bus_a_o,
   output wire [DW-1:0] bus_b_o,
   output wire [DW-1:0] third_output_bus_o,
   output wire [DW-1:0] fourth_output_bus_o,
   output reg forwarded_output_clock_o
);

   // Calibration pin detector states
   localparam [2:0] P_LOW = 3'b001;
   localparam [2:0] P_HIGH = 3'b010;
   localparam [2:0] P_DONE = 3'b100;
   // Calibration states
   localparam [2:0] C_WAIT = 3'b001;
   localparam [2:0] C_IDLE = 3'b010;
   localparam [2:0] C_RUN = 3'b100;

   // True when a tri-level strap floats or sits mid-supply
   function is_mid;
      input [1:0] code;
      begin
         is_mid = (code == `STRAP_MID);
      end
   endfunction

   // True when a tri-level strap is firmly high
   function is_high;
      input [1:0] code;
      begin
         is_high = (code == `STRAP_HIGH);
      end
   endfunction

   wire [17:0] sync_w; // Synchronised pins
   wire [1:0] range_s; // Range strap code
   wire [1:0] edge_s; // Edge strap code
   wire swing_s;
   wire dly_s;
   wire ckrst_s;
   wire pd_s;
   wire cal_s;
   wire inclk_s;
   wire [DW-1:0] smp_s;
   reg inclk_prev_q; // Previous input clock level
   reg ckrst_prev_q; // Previous clock reset level
   wire rise_w; // Input clock rising edge
   wire fall_w; // Input clock falling edge
   reg [7:0] ctrl_q; // Control register
   wire ext_w; // Extended control mode
   reg started_q; // First falling edge seen since alignment
   wire word_w; // Whole word published
   wire mid_w; // Half a word period
   reg [2:0] pst_q; // Calibration pin detector state
   reg [6:0] pcnt_q; // Cycles in the current pin phase
   reg cal_go_q; // One-cycle calibration request
   reg [2:0] cst_q; // Calibration state
   reg [23:0] ccnt_q; // Calibration cycle counter
   wire [7:0] stat_w; // Status word
   wire acc_w; // New bus access

   // Bring every pin into this clock domain
   pin_sync #(
      .W(18)
   ) u_sync (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .pin_i({sample_i, in_clk_i, cal_pin_i, power_down_pin_i, output_clock_reset_i,
              calibration_delay_select_i, output_swing_select_i, edge_strap_i,
              range_strap_i}),
      .sync_o(sync_w)
   );

   assign range_s = sync_w[1:0];
   assign edge_s = sync_w[3:2];
   assign swing_s = sync_w[4];
   assign dly_s = sync_w[5];
   assign ckrst_s = sync_w[6];
   assign pd_s = sync_w[7];
   assign cal_s = sync_w[8];
   assign inclk_s = sync_w[9];
   assign smp_s = sync_w[17:10];

   // Extended mode straight from the range strap
   assign ext_w = is_mid(range_s); // R1

   // Both input clock edges, after synchronisation
   assign rise_w = inclk_s & ~inclk_prev_q; // R13
   assign fall_w = ~inclk_s & inclk_prev_q; // R13 R19

   // Edge history of input clock and clock reset pin
   always @(posedge clk_i) begin
      if (rst_i) begin
         inclk_prev_q <= 1'b0;
         ckrst_prev_q <= 1'b0;
      end else begin
         inclk_prev_q <= inclk_s;
         ckrst_prev_q <= ckrst_s;
      end
   end

   // Settings: straps outside extended mode, register inside it
   always @(posedge clk_i) begin
      if (rst_i) begin
         extended_control_enable_o <= 1'b0;
         range_870_o <= 1'b0;
         swing_normal_o <= 1'b1;
         ddr_o <= 1'b0;
         edge_rise_o <= 1'b0;
         half_mode_o <= 1'b0;
         power_down_o <= 1'b0;
         serial_clk_o <= 1'b0;
         serial_data_in_o <= 1'b0;
         serial_select_o <= 1'b0;
      end else begin
         extended_control_enable_o <= ext_w; // R1
         power_down_o <= pd_s; // R9
         if (ext_w) begin
            // Shared pins feed the serial port, register drives settings
            serial_clk_o <= swing_s; // R4
            serial_data_in_o <= is_high(edge_s); // R7
            serial_select_o <= dly_s; // R12
            range_870_o <= ctrl_q[`CTRL_RANGE]; // R20
            swing_normal_o <= ctrl_q[`CTRL_SWING]; // R20
            edge_rise_o <= ctrl_q[`CTRL_EDGE]; // R20
            ddr_o <= ctrl_q[`CTRL_DDR]; // R20
            half_mode_o <= ctrl_q[`CTRL_HALF]; // R16
         end else begin
            // Strap meanings, serial port idle
            serial_clk_o <= 1'b0;
            serial_data_in_o <= 1'b0;
            serial_select_o <= 1'b0;
            range_870_o <= is_high(range_s); // R2
            swing_normal_o <= swing_s; // R3
            edge_rise_o <= is_high(edge_s); // R5
            ddr_o <= is_mid(edge_s); // R6
            half_mode_o <= 1'b0; // R15
         end
      end
   end

   // Alignment: after clock reset or power-down wait for a falling edge
   always @(posedge clk_i) begin
      if (rst_i || ckrst_s || power_down_o) begin
         started_q <= 1'b0; // R8 R9
      end else if (fall_w) begin
         started_q <= 1'b1; // R19
      end
   end

   // Sample framing, offset binary by flipping the sign bit
   sample_demux #(
      .DW(DW)
   ) u_demux (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .smp_valid_i((rise_w | fall_w) & (started_q | fall_w) & ~power_down_o
                   & ~ckrst_s), // R13 R19 R9
      .smp_i({~smp_s[DW-1], smp_s[DW-2:0]}), // R14 R17
      .half_i(half_mode_o),
      .align_i((ckrst_s & ~ckrst_prev_q) | power_down_o), // R8 R9
      .bus_a_o(bus_a_o),
      .bus_b_o(bus_b_o),
      .bus_c_o(third_output_bus_o),
      .bus_d_o(fourth_output_bus_o),
      .word_o(word_w),
      .mid_o(mid_w)
   );

   // Forwarded clock: toggles per word in DDR, full period per word in SDR
   always @(posedge clk_i) begin
      if (rst_i || ckrst_s || power_down_o) begin
         forwarded_output_clock_o <= 1'b0; // R8 R9
      end else if (ddr_o) begin
         if (word_w) begin
            forwarded_output_clock_o <= ~forwarded_output_clock_o; // R6
         end
      end else if (word_w) begin
         forwarded_output_clock_o <= edge_rise_o; // R5
      end else if (mid_w) begin
         forwarded_output_clock_o <= ~edge_rise_o; // R5
      end
   end

   // Calibrate pin: 80 low cycles then 80 high cycles of the input clock
   always @(posedge clk_i) begin
      if (rst_i) begin
         pst_q <= P_LOW;
         pcnt_q <= 7'h00;
         cal_go_q <= 1'b0;
      end else begin
         cal_go_q <= 1'b0;
         case (pst_q)
            P_LOW: begin
               if (cal_s) begin
                  pcnt_q <= 7'h00;
                  if (pcnt_q >= `CAL_SEQ_MIN) begin
                     pst_q <= P_HIGH; // R10
                  end
               end else if (rise_w && pcnt_q < `CAL_SEQ_MIN) begin
                  pcnt_q <= pcnt_q + 7'h01;
               end
            end
            P_HIGH: begin
               if (!cal_s) begin
                  pcnt_q <= 7'h00;
                  pst_q <= P_LOW;
               end else if (pcnt_q >= `CAL_SEQ_MIN) begin
                  cal_go_q <= 1'b1; // R10
                  pst_q <= P_DONE;
               end else if (rise_w) begin
                  pcnt_q <= pcnt_q + 7'h01;
               end
            end
            P_DONE: begin
               if (!cal_s) begin
                  pcnt_q <= 7'h00;
                  pst_q <= P_LOW;
               end
            end
            default: begin
               pst_q <= P_LOW;
               pcnt_q <= 7'h00;
            end
         endcase
      end
   end

   // Calibration: power-up delay, then run; restarts on command
   always @(posedge clk_i) begin
      if (rst_i) begin
         cst_q <= C_WAIT;
         ccnt_q <= 24'h000000;
         calibration_running_flag_o <= 1'b0;
      end else if (power_down_o) begin
         cst_q <= C_WAIT; // R9
         ccnt_q <= 24'h000000;
         calibration_running_flag_o <= 1'b0;
      end else begin
         case (cst_q)
            C_WAIT: begin
               if (rise_w) begin
                  ccnt_q <= ccnt_q + 24'h000001;
               end
               if (ccnt_q >= ((!ext_w && dly_s) ? CAL_DLY_LONG : CAL_DLY_SHORT)) begin
                  cst_q <= C_RUN; // R11 R12
                  ccnt_q <= 24'h000000;
                  calibration_running_flag_o <= 1'b1; // R18
               end
            end
            C_IDLE: begin
               if (cal_go_q) begin
                  cst_q <= C_RUN; // R10
                  ccnt_q <= 24'h000000;
                  calibration_running_flag_o <= 1'b1; // R18
               end
            end
            C_RUN: begin
               if (rise_w) begin
                  ccnt_q <= ccnt_q + 24'h000001;
               end
               if (ccnt_q >= CAL_LEN) begin
                  cst_q <= C_IDLE;
                  calibration_running_flag_o <= 1'b0; // R18
               end
            end
            default: begin
               cst_q <= C_IDLE;
               calibration_running_flag_o <= 1'b0;
            end
         endcase
      end
   end

   // Status word
   assign stat_w = {half_mode_o, edge_rise_o, ddr_o, swing_normal_o, range_870_o,
                    power_down_o, calibration_running_flag_o, extended_control_enable_o};
   assign acc_w = wb_cyc_i & wb_stb_i & ~wb_ack_o;

   // Wishbone slave: answer one cycle after the request, writes with ack
   always @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
         ctrl_q <= `CTRL_RESET;
      end else begin
         wb_ack_o <= acc_w;
         // Write lands at the edge where the master samples ack high
         if (wb_ack_o && wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0]
             && wb_adr_i == `REG_CTRL) begin
            ctrl_q <= wb_dat_i[7:0];
         end
         if (acc_w) begin
            if (wb_we_i) begin
               wb_dat_o <= 32'h00000000;
            end else if (wb_adr_i == `REG_CTRL) begin
               wb_dat_o <= {24'h000000, ctrl_q};
            end else if (wb_adr_i == `REG_STAT) begin
               wb_dat_o <= {24'h000000, stat_w};
            end else begin
               wb_dat_o <= 32'h00000000; // Unmapped reads zero
            end
         end
      end
   end

endmodule

//--- common/adc_ctrl_defs.vh
// Constants for the converter strap, mode and framing control block
`ifndef ADC_CTRL_DEFS_VH
`define ADC_CTRL_DEFS_VH

// Register byte offsets on the Wishbone bus
`define REG_CTRL 4'h0
`define REG_STAT 4'h4

// Control register fields, used only in extended control mode
`define CTRL_RANGE 0
`define CTRL_SWING 1
`define CTRL_EDGE 2
`define CTRL_DDR 3
`define CTRL_HALF 4
`define CTRL_RESET 8'h0A

// Status register fields
`define STAT_EXT 0
`define STAT_CAL 1
`define STAT_PD 2
`define STAT_RANGE 3
`define STAT_SWING 4
`define STAT_DDR 5
`define STAT_EDGE 6
`define STAT_HALF 7

// Tri-level strap codes
`define STRAP_LOW 2'h0
`define STRAP_HIGH 2'h1
`define STRAP_MID 2'h2

// Calibration pin phases, in input clock cycles
`define CAL_SEQ_MIN 7'h50

// Default counts, in input clock cycles
`define CAL_DLY_SHORT_DEF 24'h000400
`define CAL_DLY_LONG_DEF 24'h008000
`define CAL_LEN_DEF 24'h000800

`endif

//--- hw/pin_sync.v
// Two-flop synchroniser for a group of pin inputs
module pin_sync #(
   parameter W = 1
) (
   // Clock and reset
   input wire clk_i,
   input wire rst_i,
   // Raw pins and synchronised copy
   input wire [W-1:0] pin_i,
   output reg [W-1:0] sync_o
);

   reg [W-1:0] meta_q; // First stage, read only by the second

   // Two stages in series
   always @(posedge clk_i) begin
      if (rst_i) begin
         meta_q <= {W{1'b0}};
         sync_o <= {W{1'b0}};
      end else begin
         meta_q <= pin_i;
         sync_o <= meta_q;
      end
   end

endmodule

//--- hw/sample_demux.v
// Spreads 8-bit samples over four output buses, or two in half mode
module sample_demux #(
   parameter DW = 8
) (
   // Clock and reset
   input wire clk_i,
   input wire rst_i,
   // Sample stream
   input wire smp_valid_i,
   input wire [DW-1:0] smp_i,
   input wire half_i,
   input wire align_i,
   // Output buses and framing pulses
   output reg [DW-1:0] bus_a_o,
   output reg [DW-1:0] bus_b_o,
   output reg [DW-1:0] bus_c_o,
   output reg [DW-1:0] bus_d_o,
   output reg word_o,
   output reg mid_o
);

   reg [1:0] idx_q; // Slot of the next sample
   reg [DW-1:0] hold0_q; // Earlier samples of the word
   reg [DW-1:0] hold1_q;
   reg [DW-1:0] hold2_q;

   // Collect samples and publish a word when the set is complete
   always @(posedge clk_i) begin
      if (rst_i || align_i) begin
         idx_q <= 2'h0;
         hold0_q <= {DW{1'b0}};
         hold1_q <= {DW{1'b0}};
         hold2_q <= {DW{1'b0}};
         bus_a_o <= {DW{1'b0}};
         bus_b_o <= {DW{1'b0}};
         bus_c_o <= {DW{1'b0}};
         bus_d_o <= {DW{1'b0}};
         word_o <= 1'b0;
         mid_o <= 1'b0;
      end else begin
         word_o <= 1'b0;
         mid_o <= 1'b0;
         if (smp_valid_i) begin
            if (half_i) begin
               // Two buses, third and fourth only
               if (idx_q[0] == 1'b0) begin
                  hold0_q <= smp_i;
                  idx_q <= 2'h1;
                  mid_o <= 1'b1;
               end else begin
                  bus_c_o <= hold0_q; // R16
                  bus_d_o <= smp_i; // R16
                  idx_q <= 2'h0;
                  word_o <= 1'b1;
               end
            end else begin
               // Four buses, each at a quarter of the sample rate
               case (idx_q)
                  2'h0: begin
                     hold0_q <= smp_i;
                  end
                  2'h1: begin
                     hold1_q <= smp_i;
                     mid_o <= 1'b1;
                  end
                  2'h2: begin
                     hold2_q <= smp_i;
                  end
                  default: begin
                     bus_a_o <= hold0_q; // R15
                     bus_b_o <= hold1_q; // R15
                     bus_c_o <= hold2_q; // R15
                     bus_d_o <= smp_i; // R15
                     word_o <= 1'b1;
                  end
               endcase
               idx_q <= idx_q + 2'h1;
            end
         end
      end
   end

endmodule

//--- sim/conv_front_model.sv
// Model of the converter front end: free input clock and sample pattern
module conv_front_model (
   // Pattern control from the bench
   input wire logic hold_i,
   input wire logic [7:0] base_i,
   // Converter clock and raw sample
   output logic in_clk_o,
   output logic [7:0] sample_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] cnt_q = 8'h00; // Sample pair count, bumped after each rise

   // Input clock runs free at 80 ns
   initial begin
      sample_o = 8'h00;
      in_clk_o = 1'b0;
      forever #40 in_clk_o = ~in_clk_o;
   end

   // Sample moves mid half period, so it is stable at both edges;
   // even values meet falling edges, odd values rising ones
   always @(in_clk_o) begin
      #20;
      if (in_clk_o) begin
         cnt_q = cnt_q + 8'h01;
      end
      sample_o = hold_i ? base_i : {cnt_q[6:0], ~in_clk_o};
   end
endmodule

//--- sim/adc_mode_chk_sva.sv
// Concurrent checks on the strap, serial and register ports
`include "adc_ctrl_defs.vh"
module adc_mode_chk (
   // Clock, reset and bus
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_adr_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   // Pins
   input wire logic [1:0] range_strap_i,
   input wire logic [1:0] edge_strap_i,
   input wire logic output_swing_select_i,
   input wire logic calibration_delay_select_i,
   input wire logic power_down_pin_i,
   // Decoded settings
   input wire logic extended_control_enable_o,
   input wire logic range_870_o,
   input wire logic swing_normal_o,
   input wire logic ddr_o,
   input wire logic edge_rise_o,
   input wire logic power_down_o,
   input wire logic serial_clk_o,
   input wire logic serial_data_in_o,
   input wire logic serial_select_o
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   wire mid_w = range_strap_i == `STRAP_MID; // Range strap floating
   wire firm_w = !mid_w; // Range strap driven

   // A request being taken
   sequence take_s;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   // A read of an unmapped offset being taken
   sequence bad_rd_s;
      take_s ##0 (!wb_we_i && wb_adr_i != `REG_CTRL && wb_adr_i != `REG_STAT);
   endsequence

   bus_ack_a: assert property (take_s |=> wb_ack_o ##1 !wb_ack_o)
      else $error("ack is not a single pulse after a request");
   bad_read_a: assert property (bad_rd_s |=> wb_dat_o == 32'h0)
      else $error("unmapped read returned nonzero data");
   ext_mode_a: assert property ($stable(range_strap_i)[*5] |-> extended_control_enable_o == mid_w)
      else $error("extended mode does not follow the range strap");
   range_sel_a: assert property ((firm_w && $stable(range_strap_i))[*5] |-> range_870_o == range_strap_i[0])
      else $error("range select does not follow the strap");
   swing_sel_a: assert property ((firm_w && $stable(output_swing_select_i))[*5] |-> swing_normal_o == output_swing_select_i)
      else $error("swing does not follow its pin");
   serial_clk_a: assert property ((mid_w && $stable(output_swing_select_i))[*5] |-> serial_clk_o == output_swing_select_i)
      else $error("serial clock does not follow the swing pin");
   edge_sel_a: assert property ((firm_w && edge_strap_i != `STRAP_MID && $stable(edge_strap_i))[*5] |-> edge_rise_o == edge_strap_i[0] && !ddr_o)
      else $error("edge select does not follow the strap");
   ddr_sel_a: assert property ((firm_w && edge_strap_i == `STRAP_MID)[*5] |-> ddr_o)
      else $error("floating edge strap did not give double rate");
   serial_data_a: assert property ((mid_w && $stable(edge_strap_i))[*5] |-> serial_data_in_o == (edge_strap_i == `STRAP_HIGH))
      else $error("serial data does not follow the edge strap");
   power_down_a: assert property ($stable(power_down_pin_i)[*5] |-> power_down_o == power_down_pin_i)
      else $error("power down does not follow its pin");
   serial_sel_a: assert property ((mid_w && $stable(calibration_delay_select_i))[*5] |-> serial_select_o == calibration_delay_select_i)
      else $error("serial select does not follow the delay pin");
endmodule

bind adc_mode_ctrl adc_mode_chk chk_u (.*);

//--- sim/testbench.sv
// Self-checking bench for the converter strap and mode block
`include "adc_ctrl_defs.vh"
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   // Clock, reset and bus
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic wb_cyc_i = 1'b0;
   logic wb_stb_i = 1'b0;
   logic wb_we_i = 1'b0;
   logic [3:0] wb_adr_i = 4'h0;
   logic [3:0] wb_sel_i = 4'hF;
   logic [31:0] wb_dat_i = 32'h0;
   wire [31:0] wb_dat_o;
   wire wb_ack_o;
   // Pins and pattern control
   logic [1:0] range_strap_i = 2'h0;
   logic [1:0] edge_strap_i = 2'h1;
   logic output_swing_select_i = 1'b1;
   logic calibration_delay_select_i = 1'b0;
   logic output_clock_reset_i = 1'b0;
   logic power_down_pin_i = 1'b0;
   logic cal_pin_i = 1'b1;
   logic hold_q = 1'b0;
   logic [7:0] base_q = 8'h00;
   // Model and design outputs
   wire in_clk_i;
   wire [7:0] sample_i, bus_a_o, bus_b_o, third_output_bus_o, fourth_output_bus_o;
   wire extended_control_enable_o, range_870_o, swing_normal_o, ddr_o, edge_rise_o;
   wire half_mode_o, power_down_o, calibration_running_flag_o, forwarded_output_clock_o;
   wire serial_clk_o, serial_data_in_o, serial_select_o;
   // Bench state
   logic [31:0] seed_q = 32'h1D;
   logic [31:0] rd_q;
   int mismatches = 0;
   int compares = 0;
   int n;

   conv_front_model front_u (.hold_i(hold_q), .base_i(base_q), .in_clk_o(in_clk_i),
      .sample_o(sample_i));
   adc_mode_ctrl #(.CAL_DLY_SHORT(24'h000008), .CAL_DLY_LONG(24'h000010),
      .CAL_LEN(24'h000008)) dut_u (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
      .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .range_strap_i,
      .edge_strap_i, .output_swing_select_i, .calibration_delay_select_i,
      .output_clock_reset_i, .power_down_pin_i, .cal_pin_i, .in_clk_i, .sample_i,
      .extended_control_enable_o, .range_870_o, .swing_normal_o, .ddr_o, .edge_rise_o,
      .half_mode_o, .power_down_o, .calibration_running_flag_o, .serial_clk_o,
      .serial_data_in_o, .serial_select_o, .bus_a_o, .bus_b_o, .third_output_bus_o,
      .fourth_output_bus_o, .forwarded_output_clock_o);

   // Xorshift source
   function automatic logic [31:0] rnd();
      seed_q ^= seed_q << 13;
      seed_q ^= seed_q >> 17;
      seed_q ^= seed_q << 5;
      return seed_q;
   endfunction
   // Status expected from firm straps, calibration bit left out
   function automatic logic [31:0] firm_stat(input logic [1:0] r, input logic [1:0] e,
      input logic s);
      return {24'h0, 1'b0, e == 2'h1, e == 2'h2, s, r == 2'h1, 3'h0};
   endfunction
   // Compare and count
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         mismatches++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic tick(input int c);
      repeat (c) @(posedge clk_i);
   endtask
   task automatic note(input string t);
      $display("test finished: %s", t);
   endtask
   // One classic bus cycle, held until ack
   task automatic wb(input logic we, input logic [3:0] adr, input logic [31:0] dat);
      int k;
      k = 0;
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= adr;
      wb_dat_i <= dat;
      do begin
         @(posedge clk_i);
         k++;
      end while (wb_ack_o !== 1'b1 && k < 20);
      rd_q = wb_dat_o;
      if (k >= 20) mismatches++;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      @(posedge clk_i);
   endtask
   // Bus words against the sample pattern, at random moments
   task automatic frames(input logic half);
      for (int i = 0; i < 4; i++) begin
         tick(40 + rnd() % 8);
         if (hold_q) begin
            chk(third_output_bus_o, base_q ^ 8'h80);
            if (!half) chk(bus_a_o, base_q ^ 8'h80);
         end else if (half) begin
            chk(fourth_output_bus_o, 8'(third_output_bus_o + 8'h01));
            chk(third_output_bus_o[0], 1'b0);
         end else begin
            chk(bus_b_o, 8'(bus_a_o + 8'h01));
            chk(third_output_bus_o, 8'(bus_a_o + 8'h02));
            chk(fourth_output_bus_o, 8'(bus_a_o + 8'h03));
            chk(bus_a_o[0], 1'b0);
         end
      end
   endtask
   // Power-down, then time to the power-up calibration
   task automatic pu(input logic dly, input int lo, input int hi);
      calibration_delay_select_i <= dly;
      power_down_pin_i <= 1'b1;
      tick(20);
      chk(power_down_o, 1'b1);
      chk(calibration_running_flag_o, 1'b0);
      power_down_pin_i <= 1'b0;
      n = 0;
      while (calibration_running_flag_o !== 1'b1 && n < 400) begin
         tick(1);
         n++;
      end
      chk(n >= lo && n <= hi, 1'b1);
   endtask
   // Calibrate pin low then high for counts of input clock rises
   task automatic cal_seq(input int lo, input int hi);
      cal_pin_i <= 1'b0;
      repeat (lo) @(posedge in_clk_i);
      @(posedge clk_i);
      cal_pin_i <= 1'b1;
      repeat (hi) @(posedge in_clk_i);
      @(posedge clk_i);
   endtask
   // Verdict and end of run
   task automatic test_done();
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   // System clock
   initial begin
      forever #5 clk_i = ~clk_i;
   end
   // Watchdog
   initial begin
      #300000;
      mismatches++;
      test_done();
   end
   // Main sequence
   initial begin
      logic [1:0] r;
      logic [1:0] e;
      logic s;
      logic [31:0] w;
      tick(16);
      rst_i <= 1'b0;
      tick(1);
      wb(1'b0, `REG_CTRL, 32'h0);
      chk(rd_q, {24'h0, `CTRL_RESET});
      wb(1'b0, 4'h8, 32'h0);
      chk(rd_q, 32'h0);
      for (int i = 0; i < 8; i++) begin
         r = 2'(rnd() % 2);
         e = 2'(rnd() % 3);
         s = 1'(rnd());
         range_strap_i <= r;
         edge_strap_i <= e;
         output_swing_select_i <= s;
         w = rnd();
         wb(1'b1, `REG_CTRL, w);
         wb(1'b0, `REG_CTRL, 32'h0);
         chk(rd_q, {24'h0, w[7:0]});
         tick(6);
         wb(1'b0, `REG_STAT, 32'h0);
         chk(rd_q & 32'hFD, firm_stat(r, e, s));
      end
      note("firm straps");
      range_strap_i <= `STRAP_LOW;
      edge_strap_i <= `STRAP_HIGH;
      hold_q <= 1'b1;
      base_q <= 8'(rnd());
      frames(1'b0);
      hold_q <= 1'b0;
      frames(1'b0);
      output_clock_reset_i <= 1'b1;
      tick(4);
      chk(forwarded_output_clock_o, 1'b0);
      chk(bus_a_o, 8'h00);
      output_clock_reset_i <= 1'b0;
      frames(1'b0);
      note("quad framing");
      range_strap_i <= `STRAP_MID;
      tick(6);
      wb(1'b1, `REG_CTRL, 32'h12);
      output_swing_select_i <= 1'b0;
      tick(6);
      wb(1'b0, `REG_STAT, 32'h0);
      chk(rd_q & 32'hFD, 32'h91);
      frames(1'b1);
      pu(1'b1, 40, 100);
      note("extended mode");
      range_strap_i <= `STRAP_LOW;
      pu(1'b1, 110, 170);
      pu(1'b0, 40, 100);
      cal_seq(40, 100);
      tick(20);
      chk(calibration_running_flag_o, 1'b0);
      cal_seq(85, 76);
      chk(calibration_running_flag_o, 1'b0);
      n = 0;
      while (calibration_running_flag_o !== 1'b1 && n < 100) begin
         tick(1);
         n++;
      end
      chk(calibration_running_flag_o, 1'b1);
      n = 0;
      while (calibration_running_flag_o === 1'b1 && n < 200) begin
         tick(1);
         n++;
      end
      chk(n >= 50 && n <= 80, 1'b1);
      note("calibration");
      test_done();
   end
endmodule
